// ### shared/sscx_pkg.sv
/*
  Constants and types shared by the state save/restore controller.
  Assumes a 32-bit APB register bus and a 64-bit save area port.
*/
package sscx_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] SSCX_CMD_OFS     = 8'h00;
  localparam logic [7:0] SSCX_CTRL_OFS    = 8'h04;
  localparam logic [7:0] SSCX_FEN_LO_OFS  = 8'h08;
  localparam logic [7:0] SSCX_FEN_HI_OFS  = 8'h0C;
  localparam logic [7:0] SSCX_MSK_LO_OFS  = 8'h10;
  localparam logic [7:0] SSCX_MSK_HI_OFS  = 8'h14;
  localparam logic [7:0] SSCX_AREA_OFS    = 8'h18;
  localparam logic [7:0] SSCX_USE_LO_OFS  = 8'h1C;
  localparam logic [7:0] SSCX_USE_HI_OFS  = 8'h20;
  localparam logic [7:0] SSCX_CSR_OFS     = 8'h24;
  localparam logic [7:0] SSCX_CMSK_OFS    = 8'h28;
  localparam logic [7:0] SSCX_STAT_OFS    = 8'h2C;
  localparam logic [7:0] SSCX_REQUESTED_FEATURE_BITMAP_LO_OFS = 8'h30;
  localparam logic [7:0] SSCX_REQUESTED_FEATURE_BITMAP_HI_OFS = 8'h34;
  localparam logic [7:0] SSCX_CAP_OFS     = 8'h38;
  // Command and control field positions.
  localparam int SSCX_CMD_SAVE_BIT = 0;
  localparam int SSCX_CMD_RST_BIT  = 1;
  localparam int SSCX_OSEN_BIT     = 0;
  localparam int SSCX_AM_BIT       = 1;
  localparam int SSCX_AC_BIT       = 2;
  localparam int SSCX_TS_BIT       = 3;
  localparam int SSCX_CPL_LSB      = 4;
  localparam int SSCX_CAP_CMP_BIT  = 1;
  localparam logic [1:0] SSCX_CPL_USER = 2'h3;
  // Reset values.
  localparam logic [31:0] SSCX_CSR_RST  = 32'h0000_1F80;
  localparam logic [31:0] SSCX_CMSK_RST = 32'h0000_FFFF;
  // Save area layout in bytes from the area base.
  localparam logic [31:0] SSCX_HDR_OFS   = 32'h0000_0200;
  localparam logic [31:0] SSCX_LCSR_OFS  = 32'h0000_0018;
  localparam logic [5:0]  SSCX_ALIGN_MSK = 6'h3F;
  localparam int SSCX_HDR_WORDS = 8;
  localparam int SSCX_LAST_COMP = 62;
  localparam int SSCX_CMP_FLAG  = 63;
  // Fault codes, component operations and controller states.
  typedef enum logic [2:0] {
    SSCX_FLT_NONE, SSCX_FLT_UD, SSCX_FLT_NM, SSCX_FLT_GP, SSCX_FLT_AC
  } sscx_fault_t;
  typedef enum logic [1:0] {
    SSCX_OP_STORE, SSCX_OP_LOAD, SSCX_OP_INIT
  } sscx_op_t;
  typedef enum {
    SSCX_IDLE, SSCX_HDR_RD, SSCX_HDR_WR, SSCX_CHECK, SSCX_CSR_RD,
    SSCX_CSR_WR, SSCX_COMP, SSCX_DONE
  } sscx_state_t;
endpackage : sscx_pkg

// ### src/sscx_ctrl.sv
/*
  State save/restore controller: fault checks, header update, and the
  per-component store, load or initialise sequence, run from APB.
  Assumes one clock, a save area port that answers with mem_ready_i and a
  component datapath that answers with comp_ready_i, both on mclk_i.
*/
// Functional notes
// - Requested bitmap is feature enable AND the 64-bit instruction mask.
// - Save or restore with save enable clear gives invalid opcode fault.
// - Task switched flag set gives device unavailable fault.
// - Save area not 64-byte aligned gives general protection fault.
// - Mask enable, level 3 and check flag give alignment fault, not GP.
// - Save updates header state bits from in-use bits where requested.
// - In-use bit 1 covers vector registers only, not the SIMD control.
// - Save writes only the header state vector, never the compaction word.
// - Save stores every requested component, always in standard layout.
// - Save stores SIMD control and mask when requested bit 1 or 2 set.
// - Restore picks compacted form when compaction bit 63 is set.
// - Standard restore faults on unenabled state bits, bytes 23:8 nonzero.
// - Requested components initialise on state bit 0, load on bit 1.
// - Standard restore loads SIMD control on bit 1 or 2; faults if bad.
// - Compacted form faults on bad compaction, state bits or bytes 63:16.
// - Compacted restore with requested bit 1 set, state bit 1 clear sets SIMD control to 1F80.
// - Compacted restore initialises even when compaction bit is clear.
// - Compacted restore uses compacted layout for components 2 to 62.
// - Compacted form loads SIMD control only on requested, state bit 1.
// - No compaction support means standard form; capability bit 1 tells.
`timescale 1ns/10ps
module sscx_ctrl
  import sscx_pkg::*;
#(
  parameter bit CMP_SUPPORT = 1'b1          // Compacted restore present.
) (
  input  wire logic        mclk_i,          // Core clock, 250 MHz.
  input  wire logic        nrst_i,          // Async reset, active low.
  input  wire logic        psel_i,          // APB select.
  input  wire logic        penable_i,       // APB access phase.
  input  wire logic        pwrite_i,        // APB write.
  input  wire logic [7:0]  paddr_i,         // APB byte address.
  input  wire logic [31:0] pwdata_i,        // APB write data.
  output logic      [31:0] prdata_o,        // APB read data.
  output logic             pready_o,        // APB ready.
  output logic             pslverr_o,       // APB error, unmapped.
  output logic             mem_req_o,       // Save area request.
  output logic             mem_we_o,        // Save area write.
  output logic      [31:0] mem_addr_o,      // Save area byte address.
  output logic      [63:0] mem_wdata_o,     // Save area write data.
  input  wire logic        mem_ready_i,     // Save area answer.
  input  wire logic [63:0] mem_rdata_i,     // Save area read data.
  output logic             comp_req_o,      // Component request.
  output logic      [5:0]  comp_idx_o,      // Component index.
  output sscx_op_t         comp_op_o,       // Store, load or init.
  output logic             comp_compact_o,  // Compacted layout.
  input  wire logic        comp_ready_i     // Component answer.
);
  sscx_state_t state_q;
  sscx_fault_t fault_q;
  logic [31:0] ctrl_q, area_q, csr_q, cmsk_q, csr_new_q, addr_q;
  logic [63:0] fen_q, imask_q, use_q, requested_feature_bitmap_q, xsv_q, xcv_q;
  logic        save_q, done_q, hinz_q, mnz_q, w2nz_q, cmp_q, csr_upd_q;
  logic [2:0]  hcnt_q;
  logic [5:0]  idx_q;

  // APB decode; the slave never inserts wait states.
  wire apb_acc = psel_i & penable_i;
  wire apb_wr  = apb_acc & pwrite_i;
  wire idle    = (state_q == SSCX_IDLE);
  wire start   = apb_wr & idle & (paddr_i == SSCX_CMD_OFS) &
                 (pwdata_i[SSCX_CMD_SAVE_BIT] | pwdata_i[SSCX_CMD_RST_BIT]);
  wire start_sv = pwdata_i[SSCX_CMD_SAVE_BIT];
  wire [63:0] requested_feature_bitmap_w = fen_q & imask_q;
  wire os_en   = ctrl_q[SSCX_OSEN_BIT];
  wire ts_flag = ctrl_q[SSCX_TS_BIT];
  wire misal   = (area_q[5:0] & SSCX_ALIGN_MSK) != 6'h00;
  wire ac_cond = ctrl_q[SSCX_AM_BIT] & ctrl_q[SSCX_AC_BIT] &
                 (ctrl_q[SSCX_CPL_LSB +: 2] == SSCX_CPL_USER);
  // Common fault priority: invalid opcode, then device, then alignment.
  wire sscx_fault_t start_flt =
    !os_en  ? SSCX_FLT_UD :
    ts_flag ? SSCX_FLT_NM :
    misal   ? (ac_cond ? SSCX_FLT_AC :
               SSCX_FLT_GP) :
              SSCX_FLT_NONE;

  // Save header: unrequested bits kept, requested bits from in-use bits.
  // In-use bit 1 is software's view of the vector registers alone.
  wire [63:0] xsv_new = (xsv_q & ~requested_feature_bitmap_q) | (use_q & requested_feature_bitmap_q);
  // Restore header checks. The standard form looks at bytes 23:8 alone and
  // tolerates reserved words above them; the compacted form rejects nonzero bytes 63:16.
  wire std_bad = ((xsv_q & ~fen_q) != 64'h0) | mnz_q | w2nz_q;
  wire cmp_bad = ((xcv_q[62:0] & ~fen_q[62:0]) != 63'h0) |
                 ((xsv_q & ~xcv_q) != 64'h0) | hinz_q;
  wire cmp_form = CMP_SUPPORT & xcv_q[SSCX_CMP_FLAG];
  wire csr_save = requested_feature_bitmap_q[1] | requested_feature_bitmap_q[2];
  wire csr_ld   = cmp_q ? (requested_feature_bitmap_q[1] & xsv_q[1]) :
                          (requested_feature_bitmap_q[1] | requested_feature_bitmap_q[2]);
  wire csr_ini  = cmp_q & requested_feature_bitmap_q[1] & ~xsv_q[1];
  wire csr_bad  = (mem_rdata_i[31:0] & ~cmsk_q) != 32'h0;
  wire last_idx = (idx_q == 6'(SSCX_LAST_COMP));
  wire [31:0] hdr_base = area_q + SSCX_HDR_OFS;

  // Register file writes; the restore commits the SIMD control at the end.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q  <= 32'h0000_0000;
      area_q  <= 32'h0000_0000;
      fen_q   <= 64'h0000_0000_0000_0000;
      imask_q <= 64'h0000_0000_0000_0000;
      use_q   <= 64'h0000_0000_0000_0000;
      csr_q   <= SSCX_CSR_RST;
      cmsk_q  <= SSCX_CMSK_RST;
    end else if (state_q == SSCX_DONE && csr_upd_q) begin
      csr_q <= csr_new_q;
    end else if (apb_wr && idle) begin
      case (paddr_i)
        SSCX_CTRL_OFS:   ctrl_q         <= pwdata_i;
        SSCX_AREA_OFS:   area_q         <= pwdata_i;
        SSCX_FEN_LO_OFS: fen_q[31:0]    <= pwdata_i;
        SSCX_FEN_HI_OFS: fen_q[63:32]   <= pwdata_i;
        SSCX_MSK_LO_OFS: imask_q[31:0]  <= pwdata_i;
        SSCX_MSK_HI_OFS: imask_q[63:32] <= pwdata_i;
        SSCX_USE_LO_OFS: use_q[31:0]    <= pwdata_i;
        SSCX_USE_HI_OFS: use_q[63:32]   <= pwdata_i;
        SSCX_CSR_OFS:    csr_q          <= pwdata_i;
        SSCX_CMSK_OFS:   cmsk_q         <= pwdata_i;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets read zero and flag an error.
  wire [31:0] stat_w = {24'h0, 1'b0, cmp_q, done_q, ~idle, 1'b0, fault_q};
  wire [31:0] cap_w  = 32'(CMP_SUPPORT) << SSCX_CAP_CMP_BIT;
  wire mapped = (paddr_i <= SSCX_CAP_OFS) && (paddr_i[1:0] == 2'b00);
  always_comb begin
    case (paddr_i)
      SSCX_CTRL_OFS:    prdata_o = ctrl_q;
      SSCX_AREA_OFS:    prdata_o = area_q;
      SSCX_FEN_LO_OFS:  prdata_o = fen_q[31:0];
      SSCX_FEN_HI_OFS:  prdata_o = fen_q[63:32];
      SSCX_MSK_LO_OFS:  prdata_o = imask_q[31:0];
      SSCX_MSK_HI_OFS:  prdata_o = imask_q[63:32];
      SSCX_USE_LO_OFS:  prdata_o = use_q[31:0];
      SSCX_USE_HI_OFS:  prdata_o = use_q[63:32];
      SSCX_CSR_OFS:     prdata_o = csr_q;
      SSCX_CMSK_OFS:    prdata_o = cmsk_q;
      SSCX_STAT_OFS:    prdata_o = stat_w;
      SSCX_REQUESTED_FEATURE_BITMAP_LO_OFS: prdata_o = requested_feature_bitmap_q[31:0];
      SSCX_REQUESTED_FEATURE_BITMAP_HI_OFS: prdata_o = requested_feature_bitmap_q[63:32];
      SSCX_CAP_OFS:     prdata_o = cap_w;
      default:          prdata_o = 32'h0000_0000;
    endcase
  end
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc & ~mapped;

  // Memory and component requests are decoded from the state. A skipped
  // control load raises no request, so the area never sees a dropped read.
  assign mem_req_o = (state_q == SSCX_HDR_RD) | (state_q == SSCX_HDR_WR) |
                     ((state_q == SSCX_CSR_RD) & csr_ld) |
                     (state_q == SSCX_CSR_WR);
  assign mem_we_o  = (state_q == SSCX_HDR_WR) |
                     (state_q == SSCX_CSR_WR);
  assign comp_req_o = (state_q == SSCX_COMP) & requested_feature_bitmap_q[idx_q];
  assign comp_idx_o = idx_q;
  assign comp_op_o  = save_q ? SSCX_OP_STORE :
                      (xsv_q[idx_q] ? SSCX_OP_LOAD :
                                      SSCX_OP_INIT);
  assign comp_compact_o = ~save_q & cmp_q & (idx_q >= 6'd2);

  // Sequencer. Every fault is decided before the first write, so a
  // faulting instruction leaves memory and the SIMD control untouched.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= SSCX_IDLE;
      fault_q <= SSCX_FLT_NONE;
      {save_q, done_q, hinz_q, mnz_q, w2nz_q, cmp_q, csr_upd_q} <= 7'h00;
      requested_feature_bitmap_q  <= 64'h0000_0000_0000_0000;
      xsv_q   <= 64'h0000_0000_0000_0000;
      xcv_q   <= 64'h0000_0000_0000_0000;
      addr_q  <= 32'h0000_0000;
      csr_new_q <= SSCX_CSR_RST;
      mem_addr_o  <= 32'h0000_0000;
      mem_wdata_o <= 64'h0000_0000_0000_0000;
      hcnt_q  <= 3'h0;
      idx_q   <= 6'h00;
    end else begin
      case (state_q)
        SSCX_IDLE: if (start) begin
          save_q  <= start_sv;
          requested_feature_bitmap_q  <= requested_feature_bitmap_w;
          fault_q <= start_flt;
          done_q  <= 1'b0;
          {hinz_q, mnz_q, w2nz_q, cmp_q, csr_upd_q} <= 5'h00;
          xcv_q   <= 64'h0000_0000_0000_0000;
          hcnt_q  <= 3'h0;
          idx_q   <= 6'h00;
          mem_addr_o <= hdr_base;
          state_q <= (start_flt == SSCX_FLT_NONE) ? SSCX_HDR_RD :
                                                    SSCX_DONE;
        end
        SSCX_HDR_RD: if (mem_ready_i) begin
          case (hcnt_q)
            3'h0: xsv_q <= mem_rdata_i;
            3'h1: begin
              xcv_q <= mem_rdata_i;
              mnz_q <= mem_rdata_i != 64'h0;
            end
            3'h2: begin
              w2nz_q <= mem_rdata_i != 64'h0;
              hinz_q <= hinz_q | (mem_rdata_i != 64'h0);
            end
            default: hinz_q <= hinz_q | (mem_rdata_i != 64'h0);
          endcase
          hcnt_q <= hcnt_q + 3'h1;
          mem_addr_o <= mem_addr_o + 32'h0000_0008;
          if (save_q) begin
            mem_addr_o <= hdr_base;
            mem_wdata_o <= (mem_rdata_i & ~requested_feature_bitmap_q) | (use_q & requested_feature_bitmap_q);
            state_q <= SSCX_HDR_WR;
          end else if (hcnt_q == 3'(SSCX_HDR_WORDS - 1)) begin
            state_q <= SSCX_CHECK;
          end
        end
        SSCX_HDR_WR: if (mem_ready_i) begin
          mem_addr_o  <= area_q + SSCX_LCSR_OFS;
          mem_wdata_o <= {cmsk_q, csr_q};
          state_q <= csr_save ? SSCX_CSR_WR : SSCX_COMP;
        end
        SSCX_CHECK: begin
          cmp_q <= cmp_form;
          mem_addr_o <= area_q + SSCX_LCSR_OFS;
          if (cmp_form ? cmp_bad : std_bad) begin
            fault_q <= SSCX_FLT_GP;
            state_q <= SSCX_DONE;
          end else begin
            state_q <= SSCX_CSR_RD;
          end
        end
        SSCX_CSR_RD: if (!csr_ld) begin
          csr_upd_q <= csr_ini;
          csr_new_q <= SSCX_CSR_RST;
          state_q <= SSCX_COMP;
        end else if (mem_ready_i) begin
          csr_upd_q <= ~csr_bad;
          csr_new_q <= mem_rdata_i[31:0];
          if (csr_bad) begin
            fault_q <= SSCX_FLT_GP;
            state_q <= SSCX_DONE;
          end else begin
            state_q <= SSCX_COMP;
          end
        end
        SSCX_CSR_WR: if (mem_ready_i) begin
          state_q <= SSCX_COMP;
        end
        SSCX_COMP: if (!requested_feature_bitmap_q[idx_q] || comp_ready_i) begin
          idx_q <= idx_q + 6'h01;
          if (last_idx) begin
            state_q <= SSCX_DONE;
          end
        end
        SSCX_DONE: begin
          done_q  <= 1'b1;
          csr_upd_q <= 1'b0;
          state_q <= SSCX_IDLE;
        end
        default: state_q <= SSCX_IDLE;
      endcase
    end
  end

  // The restore in the last case never reads the state during save, so
  // xsv_new is only a check on the written header.
  property p_requested_feature_bitmap;
    @(posedge mclk_i) disable iff (!nrst_i)
      start |=> requested_feature_bitmap_q == $past(fen_q & imask_q);
  endproperty
  a_requested_feature_bitmap: assert property (p_requested_feature_bitmap) else $error("bad bitmap");
  property p_ud;
    @(posedge mclk_i) disable iff (!nrst_i)
      start && !os_en |=> fault_q == SSCX_FLT_UD && state_q == SSCX_DONE
        ##1 done_q && !mem_req_o;
  endproperty
  a_ud: assert property (p_ud) else $error("no invalid opcode");
  property p_nm;
    @(posedge mclk_i) disable iff (!nrst_i)
      start && os_en && ts_flag |=> fault_q == SSCX_FLT_NM;
  endproperty
  a_nm: assert property (p_nm) else $error("no device fault");
  property p_gp;
    @(posedge mclk_i) disable iff (!nrst_i)
      start && os_en && !ts_flag && misal |=>
        fault_q == ($past(ac_cond) ? SSCX_FLT_AC : SSCX_FLT_GP);
  endproperty
  a_gp: assert property (p_gp) else $error("no alignment fault");
  property p_hdr;
    @(posedge mclk_i) disable iff (!nrst_i)
      state_q == SSCX_HDR_WR |-> mem_wdata_o == xsv_new &&
        mem_addr_o == hdr_base;
  endproperty
  a_hdr: assert property (p_hdr) else $error("bad header");
  property p_wr;
    @(posedge mclk_i) disable iff (!nrst_i)
      mem_req_o && mem_we_o |-> save_q && fault_q == SSCX_FLT_NONE &&
        (mem_addr_o == hdr_base || mem_addr_o == area_q + SSCX_LCSR_OFS);
  endproperty
  a_wr: assert property (p_wr) else $error("stray write");
  property p_csrw;
    @(posedge mclk_i) disable iff (!nrst_i)
      $rose(state_q == SSCX_COMP) && save_q |->
        $past(state_q == SSCX_CSR_WR) == csr_save;
  endproperty
  a_csrw: assert property (p_csrw) else $error("control not saved");
  property p_op;
    @(posedge mclk_i) disable iff (!nrst_i)
      comp_req_o |-> requested_feature_bitmap_q[idx_q] && comp_op_o == (save_q ? SSCX_OP_STORE :
        xsv_q[idx_q] ? SSCX_OP_LOAD : SSCX_OP_INIT);
  endproperty
  a_op: assert property (p_op) else $error("bad component op");
  property p_ini;
    @(posedge mclk_i) disable iff (!nrst_i)
      state_q == SSCX_DONE && fault_q == SSCX_FLT_NONE && !save_q &&
        cmp_q && requested_feature_bitmap_q[1] && !xsv_q[1] |=> csr_q == SSCX_CSR_RST;
  endproperty
  a_ini: assert property (p_ini) else $error("control not reset");
  property p_hflt;
    @(posedge mclk_i) disable iff (!nrst_i)
      state_q == SSCX_CHECK && !xcv_q[SSCX_CMP_FLAG] &&
        ((xsv_q & ~fen_q) != 64'h0 || xcv_q != 64'h0) |=>
        fault_q == SSCX_FLT_GP && state_q == SSCX_DONE ##1 $stable(csr_q);
  endproperty
  a_hflt: assert property (p_hflt) else $error("header not refused");
  property p_csrld;
    @(posedge mclk_i) disable iff (!nrst_i)
      state_q == SSCX_CSR_RD && !cmp_q && (requested_feature_bitmap_q[1] || requested_feature_bitmap_q[2]) |->
        mem_req_o && !mem_we_o && mem_addr_o == area_q + SSCX_LCSR_OFS;
  endproperty
  a_csrld: assert property (p_csrld) else $error("no control read");
  property p_csrkp;
    @(posedge mclk_i) disable iff (!nrst_i)
      state_q == SSCX_DONE && !save_q && cmp_q && !requested_feature_bitmap_q[1] |=>
        $stable(csr_q);
  endproperty
  a_csrkp: assert property (p_csrkp) else $error("control changed");
endmodule : sscx_ctrl

// ### tb/sscx_mem_model.sv
/*
  Partner model: the save area memory and the component datapath.
  Assumes the controller holds each request until it samples ready.
*/
`timescale 1ns/10ps
module sscx_mem_model
  import sscx_pkg::*;
(
  input  wire logic        mclk_i,         // Core clock.
  input  wire logic        nrst_i,         // Async reset, active low.
  input  wire logic        slow_i,         // Adds three wait cycles.
  input  wire logic        mem_req_i,      // Save area request.
  input  wire logic        mem_we_i,       // Write when high.
  input  wire logic [31:0] mem_addr_i,     // Byte address.
  input  wire logic [63:0] mem_wdata_i,    // Write data.
  output logic             mem_ready_o,    // Answer strobe.
  output logic      [63:0] mem_rdata_o,    // Read data.
  input  wire logic        comp_req_i,     // Component request.
  input  wire logic [5:0]  comp_idx_i,     // Component index.
  input  wire sscx_op_t    comp_op_i,      // Operation.
  input  wire logic        comp_compact_i, // Compacted layout.
  output logic             comp_ready_o    // Component answer.
);
  logic [63:0] mem_q [256];
  logic [1:0]  op_q [64];
  logic        cmp_q [64];
  logic [1:0]  wait_q;
  int          wr_cnt = 0;

  // Between answers the read data toggles, so a stale sample never matches.
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_ready_o <= 1'b0;
      wait_q      <= 2'h0;
    end else if (mem_req_i && !mem_ready_o && (wait_q == {2{slow_i}})) begin
      mem_ready_o <= 1'b1;
      mem_rdata_o <= mem_q[mem_addr_i[10:3]];
      wait_q      <= 2'h0;
      if (mem_we_i) begin
        mem_q[mem_addr_i[10:3]] <= mem_wdata_i;
        wr_cnt <= wr_cnt + 1;
      end
    end else begin
      mem_ready_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_ready_o) wait_q <= wait_q + 2'h1;
    end
  end

  // The datapath answers every other cycle and logs what it was asked to do.
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      comp_ready_o <= 1'b0;
    end else begin
      comp_ready_o <= comp_req_i && !comp_ready_o;
      if (comp_req_i && comp_ready_o) begin
        op_q[comp_idx_i]  <= comp_op_i;
        cmp_q[comp_idx_i] <= comp_compact_i;
      end
    end
  end
endmodule : sscx_mem_model

// ### tb/tb.sv
/*
  Testbench for the save/restore controller: APB tasks issue commands and
  the partner model holds the save area and logs component operations.
  Assumes the partner model is compiled before this file.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h seen %h", n, e, g); end end
module tb;
  import sscx_pkg::*;
  localparam logic [31:0] AREA = 32'h0000_0400;
  localparam logic [31:0] HDR  = AREA + SSCX_HDR_OFS;
  localparam logic [31:0] LCSR = AREA + SSCX_LCSR_OFS;
  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic        slow = 1'b0;
  logic [31:0] prdata_o, mem_addr_o, rd_q;
  logic [63:0] mem_wdata_o, mem_rdata_i, requested_feature_bitmap;
  logic        pready_o, pslverr_o, mem_req_o, mem_we_o, mem_ready_i, err_q;
  logic        comp_req_o, comp_compact_o, comp_ready_i;
  logic [5:0]  comp_idx_o;
  sscx_op_t    comp_op_o;
  int          fails = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [31:0] ctl_t [5] = '{32'h8, 32'h9, 32'h1, 32'h37, 32'h27};
  logic [2:0]  flt_t [5] = '{SSCX_FLT_UD, SSCX_FLT_NM, SSCX_FLT_GP,
                            SSCX_FLT_AC, SSCX_FLT_GP};
  logic [63:0] st_t [8] = '{64'h31, 64'h21, 64'h21, 64'h21,
                           64'h21, 64'h29, 64'h21, 64'h23};
  logic [63:0] cv_t [8] = '{64'h0, 64'h1, 64'h0, 64'h0,
                           64'h8000_0000_0000_0031, 64'h8000_0000_0000_0021,
                           64'h8000_0000_0000_0021, 64'h8000_0000_0000_0023};
  logic [63:0] w2_t [8] = '{64'h0, 64'h0, 64'h1, 64'h0,
                           64'h0, 64'h0, 64'h1, 64'h0};

  sscx_ctrl #(.CMP_SUPPORT(1'b1)) dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_ready_i(mem_ready_i), .mem_rdata_i(mem_rdata_i),
    .comp_req_o(comp_req_o), .comp_idx_o(comp_idx_o), .comp_op_o(comp_op_o),
    .comp_compact_o(comp_compact_o), .comp_ready_i(comp_ready_i));
  sscx_mem_model m (.mclk_i(mclk_i), .nrst_i(nrst_i), .slow_i(slow),
    .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_ready_o(mem_ready_i),
    .mem_rdata_o(mem_rdata_i), .comp_req_i(comp_req_o),
    .comp_idx_i(comp_idx_o), .comp_op_i(comp_op_o),
    .comp_compact_i(comp_compact_o), .comp_ready_o(comp_ready_i));

  // Clock at 250 MHz and a cycle ceiling well above the whole sequence.
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test;
    end
  end

  // One APB transfer; data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    rd_q = prdata_o;
    err_q = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic w64(input logic [7:0] a, input logic [63:0] v);
    apb(1'b1, a, v[31:0]);
    apb(1'b1, a + 8'h04, v[63:32]);
  endtask : w64

  task automatic put(input logic [31:0] a, input logic [63:0] v);
    m.mem_q[a[10:3]] = v;
  endtask : put

  task automatic cfg(input logic [31:0] c, ar, input logic [63:0] en, mk);
    apb(1'b1, SSCX_CTRL_OFS, c);
    apb(1'b1, SSCX_AREA_OFS, ar);
    w64(SSCX_FEN_LO_OFS, en);
    w64(SSCX_MSK_LO_OFS, mk);
    requested_feature_bitmap = en & mk;
  endtask : cfg

  // Start a command, poll until done, check the fault code and write count.
  task automatic run(input logic [31:0] c, input logic [2:0] f, input int wr);
    int w0;
    int k;
    w0 = m.wr_cnt;
    for (k = 0; k < 64; k++) m.op_q[k] = 2'h3;
    apb(1'b1, SSCX_CMD_OFS, c);
    k = 0;
    do begin
      apb(1'b0, SSCX_STAT_OFS, 32'h0000_0000);
      k++;
    end while (rd_q[5] !== 1'b1 && k < 300);
    `CHK("fault", f, rd_q[2:0])
    `CHK("writes", wr, m.wr_cnt - w0)
  endtask : run

  // Compare the component log; an index with no expected work must be idle.
  task automatic ops(input logic [63:0] st, ld, ini, input logic c);
    logic [1:0] e;
    for (int k = 0; k < 64; k++) begin
      e = st[k] ? SSCX_OP_STORE : ld[k] ? SSCX_OP_LOAD :
          ini[k] ? SSCX_OP_INIT : 2'h3;
      `CHK("comp op", e, m.op_q[k])
      if (e !== 2'h3) `CHK("layout", c && k >= 2, m.cmp_q[k])
    end
  endtask : ops

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  initial begin
    for (int i = 0; i < 256; i++) put(32'(i) << 3, 64'h0);
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    apb(1'b0, SSCX_CSR_OFS, 32'h0000_0000);
    `CHK("csr reset", SSCX_CSR_RST, rd_q)
    apb(1'b0, SSCX_CMSK_OFS, 32'h0000_0000);
    `CHK("mask reset", SSCX_CMSK_RST, rd_q)
    apb(1'b0, SSCX_CAP_OFS, 32'h0000_0000);
    `CHK("cap", 1'b1, rd_q[SSCX_CAP_CMP_BIT])
    apb(1'b0, 8'h3C, 32'h0000_0000);
    `CHK("unmapped", 1'b1, err_q)
    // Start faults on a misaligned area, in priority order, both commands.
    for (int i = 0; i < 5; i++) for (int c = 1; c < 3; c++) begin
      cfg(ctl_t[i], AREA | 32'h0000_0020, 64'h7, 64'h7);
      run(32'(c), flt_t[i], 0);
      ops(64'h0, 64'h0, 64'h0, 1'b0);
    end
    // Save with a slow memory; bit 2 alone still stores the SIMD control.
    slow <= 1'b1;
    cfg(32'h1, AREA, 64'h1_0000_0027, 64'h1_0000_0025);
    w64(SSCX_USE_LO_OFS, 64'h0000_0000_0000_0029);
    put(HDR, 64'hF000_0000_0000_0002);
    put(HDR + 8, 64'h5);
    run(32'h1, SSCX_FLT_NONE, 2);
    apb(1'b0, SSCX_REQUESTED_FEATURE_BITMAP_LO_OFS, 32'h0000_0000);
    `CHK("requested_feature_bitmap lo", 32'h0000_0025, rd_q)
    apb(1'b0, SSCX_REQUESTED_FEATURE_BITMAP_HI_OFS, 32'h0000_0000);
    `CHK("requested_feature_bitmap hi", 32'h0000_0001, rd_q)
    `CHK("hdr", 64'hF000_0000_0000_0023, m.mem_q[HDR[10:3]])
    `CHK("cmp word", 64'h5, m.mem_q[8'hC1])
    `CHK("csr word", {SSCX_CMSK_RST, SSCX_CSR_RST}, m.mem_q[LCSR[10:3]])
    ops(requested_feature_bitmap, 64'h0, 64'h0, 1'b0);
    // In-use bit 1 stays clear although the SIMD control is not at reset.
    cfg(32'h1, AREA, 64'h7, 64'h2);
    apb(1'b1, SSCX_CSR_OFS, 32'h0000_0040);
    w64(SSCX_USE_LO_OFS, 64'h5);
    put(HDR, 64'h2);
    run(32'h1, SSCX_FLT_NONE, 2);
    `CHK("hdr bit1", 64'h0, m.mem_q[HDR[10:3]])
    `CHK("csr word", 64'h0000_FFFF_0000_0040, m.mem_q[LCSR[10:3]])
    // Standard restore loads the SIMD control although state bit 1 is 0.
    slow <= 1'b0;
    cfg(32'h1, AREA, 64'h1_0000_0027, 64'h23);
    put(HDR, 64'h21);
    put(HDR + 8, 64'h0);
    put(LCSR, 64'h0000_2A5A);
    run(32'h2, SSCX_FLT_NONE, 0);
    `CHK("std form", 1'b0, rd_q[6])
    ops(64'h0, 64'h21, 64'h2, 1'b0);
    apb(1'b0, SSCX_CSR_OFS, 32'h0000_0000);
    `CHK("csr std", 32'h0000_2A5A, rd_q)
    // Header and SIMD control faults of both forms leave state untouched.
    for (int i = 0; i < 8; i++) begin
      put(HDR, st_t[i]);
      put(HDR + 8, cv_t[i]);
      put(HDR + 16, w2_t[i]);
      put(LCSR, (i % 4 == 3) ? 64'h0001_0000 : 64'h1234);
      run(32'h2, SSCX_FLT_GP, 0);
      ops(64'h0, 64'h0, 64'h0, 1'b0);
      apb(1'b0, SSCX_CSR_OFS, 32'h0000_0000);
      `CHK("csr kept", 32'h0000_2A5A, rd_q)
    end
    // Compacted restore initialises components missing from the vector.
    put(HDR, 64'h20);
    put(HDR + 8, 64'h8000_0000_0000_0021);
    put(HDR + 16, 64'h0);
    run(32'h2, SSCX_FLT_NONE, 0);
    `CHK("cmp form", 1'b1, rd_q[6])
    ops(64'h0, 64'h20, 64'h3, 1'b1);
    apb(1'b0, SSCX_CSR_OFS, 32'h0000_0000);
    `CHK("csr init", SSCX_CSR_RST, rd_q)
    // In compacted form, requested bit 2 alone must not load the SIMD control.
    cfg(32'h1, AREA, 64'h1_0000_0027, 64'h24);
    apb(1'b1, SSCX_CSR_OFS, 32'h0000_0040);
    put(HDR, 64'h4);
    put(HDR + 8, 64'h8000_0000_0000_0004);
    run(32'h2, SSCX_FLT_NONE, 0);
    ops(64'h0, 64'h4, 64'h20, 1'b1);
    apb(1'b0, SSCX_CSR_OFS, 32'h0000_0000);
    `CHK("csr kept", 32'h0000_0040, rd_q)
    finish_test;
  end
endmodule : tb
